// ### src/acc_defines.vh
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH
// ----------------------------------------------------------------
// Register map (word index; byte address is index times four)
// ----------------------------------------------------------------
`define ACC_ADDR_W        4
`define ACC_IDX_SC        4'h0
`define ACC_IDX_SYS       4'h1
// ----------------------------------------------------------------
// Status and control fields
// ----------------------------------------------------------------
`define ACC_BIT_ENABLE    7
`define ACC_BIT_REFSEL    6
`define ACC_BIT_FLAG      5
`define ACC_BIT_IRQEN     4
`define ACC_BIT_LEVEL     3
`define ACC_BIT_PINEN     2
`define ACC_MODE_HI       1
`define ACC_MODE_LO       0
`define ACC_MODE_FALL0    2'h0
`define ACC_MODE_RISE     2'h1
`define ACC_MODE_FALL2    2'h2
`define ACC_MODE_BOTH     2'h3
// ----------------------------------------------------------------
// System option fields
// ----------------------------------------------------------------
`define ACC_BIT_CAPROUTE  0
`define ACC_BIT_CLKGATE   1
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACC_SC_RESET      8'h00
`define ACC_SYS_RESET     2'h2
`endif

// ### src/acc_analog_comparator_control.v
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`include "acc_defines.vh"
module acc_analog_comparator_control (
	input  wire       ref_clk_in,
	input  wire       resetn_in,
	input  wire [3:0] avs_address_in,
	input  wire       avs_read_in,
	input  wire       avs_write_in,
	input  wire [31:0] avs_writedata_in,
	input  wire [3:0] avs_byteenable_in,
	output reg  [31:0] avs_readdata_out,
	output reg        avs_waitrequest_out,
	input  wire       comparator_raw_in,
	input  wire       debug_pin_enable_in,
	input  wire       debug_shares_pin_in,
	output reg        comparator_enable_out,
	output reg        reference_select_out,
	output reg        positive_input_pin_release_out,
	output reg        negative_input_pin_release_out,
	output reg        comparator_out_pin_out,
	output reg        comparator_out_pin_oe_out,
	output reg        timer_two_channel_zero_out,
	output reg        capture_route_select_out,
	output reg        irq_out,
	output reg        wakeup_out
);

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	reg        enable_q;
	reg        refsel_q;
	reg        flag_q;
	reg        irqen_q;
	reg        pinen_q;
	reg  [1:0] mode_q;
	reg        caproute_q;
	reg        clkgate_q;
	reg        sync1_q;
	reg        sync2_q;
	reg        level_q;
	reg        ack_q;
	reg        dbg_en_s1_q;
	reg        dbg_en_s2_q;
	reg        dbg_sh_s1_q;
	reg        dbg_sh_s2_q;
	wire       run;
	wire       rise;
	wire       fall;
	reg        event_d;
	wire       acc;
	wire       wr_sc;
	wire       wr_sys;
	wire       hit;
	reg  [7:0] sc_view;

	function is_idx;
		input [3:0] a;
		input [3:0] idx;
		begin
			is_idx = (a == idx);
		end
	endfunction

	// Gated clock modelled as a functional enable; a real gate
	// cell would sit outside this block.
	assign run    = enable_q & clkgate_q;
	assign acc    = (avs_read_in | avs_write_in) & ~ack_q;
	// Writes land at the edge where the master sees waitrequest low
	assign wr_sc  = avs_write_in & ack_q & avs_byteenable_in[0] &
		is_idx(avs_address_in, `ACC_IDX_SC);
	assign wr_sys = avs_write_in & ack_q & avs_byteenable_in[0] &
		is_idx(avs_address_in, `ACC_IDX_SYS);
	assign hit    = is_idx(avs_address_in, `ACC_IDX_SC) |
		is_idx(avs_address_in, `ACC_IDX_SYS);

	// ------------------------------------------------------------
	// Synchroniser and edge detect
	// ------------------------------------------------------------
	// The analog core decides plus > minus; only its level enters.
	always @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1_q     <= 1'b0;
			sync2_q     <= 1'b0;
			level_q     <= 1'b0;
			dbg_en_s1_q <= 1'b0;
			dbg_en_s2_q <= 1'b0;
			dbg_sh_s1_q <= 1'b0;
			dbg_sh_s2_q <= 1'b0;
		end else begin
			// Debug pin levels are asynchronous too
			dbg_en_s1_q <= debug_pin_enable_in;
			dbg_en_s2_q <= dbg_en_s1_q;
			dbg_sh_s1_q <= debug_shares_pin_in;
			dbg_sh_s2_q <= dbg_sh_s1_q;
			sync1_q <= comparator_raw_in;
			sync2_q <= sync1_q;
			level_q <= run ? sync2_q : 1'b0;
		end
	end

	assign rise = run & sync2_q & ~level_q;
	assign fall = run & ~sync2_q & level_q;

	// No stop or wait input: the block keeps running in those modes.
	always @* begin
		case (mode_q)
			`ACC_MODE_RISE:  event_d = rise;
			`ACC_MODE_BOTH:  event_d = rise | fall;
			`ACC_MODE_FALL2: event_d = fall;
			default:         event_d = fall;
		endcase
	end

	// ------------------------------------------------------------
	// Registers; reset covers stop exit and deep stop wake
	// ------------------------------------------------------------
	always @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			enable_q   <= 1'b0;
			refsel_q   <= 1'b0;
			flag_q     <= 1'b0;
			irqen_q    <= 1'b0;
			pinen_q    <= 1'b0;
			mode_q     <= 2'h0;
			caproute_q <= 1'b0;
			clkgate_q  <= 1'b1;
		end else begin
			if (clkgate_q && wr_sc) begin
				enable_q <= avs_writedata_in[`ACC_BIT_ENABLE];
				refsel_q <= avs_writedata_in[`ACC_BIT_REFSEL];
				irqen_q  <= avs_writedata_in[`ACC_BIT_IRQEN];
				pinen_q  <= avs_writedata_in[`ACC_BIT_PINEN];
				mode_q   <= avs_writedata_in[`ACC_MODE_HI:`ACC_MODE_LO];
			end
			if (wr_sys) begin
				caproute_q <= avs_writedata_in[`ACC_BIT_CAPROUTE];
				clkgate_q  <= avs_writedata_in[`ACC_BIT_CLKGATE];
			end
			// Set wins over a simultaneous write-one clear
			if (event_d)
				flag_q <= 1'b1;
			else if (clkgate_q && wr_sc &&
				avs_writedata_in[`ACC_BIT_FLAG])
				flag_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Avalon slave: one wait cycle, then acknowledge
	// ------------------------------------------------------------
	always @* begin
		sc_view = 8'h00;
		sc_view[`ACC_BIT_ENABLE] = enable_q;
		sc_view[`ACC_BIT_REFSEL] = refsel_q;
		sc_view[`ACC_BIT_FLAG]   = flag_q;
		sc_view[`ACC_BIT_IRQEN]  = irqen_q;
		sc_view[`ACC_BIT_LEVEL]  = level_q;
		sc_view[`ACC_BIT_PINEN]  = pinen_q;
		sc_view[`ACC_MODE_HI:`ACC_MODE_LO] = mode_q;
	end

	always @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ack_q               <= 1'b0;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= 32'h0000_0000;
		end else begin
			ack_q               <= acc;
			avs_waitrequest_out <= ~acc;
			if (acc && avs_read_in) begin
				if (is_idx(avs_address_in, `ACC_IDX_SC))
					avs_readdata_out <= {24'h00_0000, sc_view};
				else if (is_idx(avs_address_in, `ACC_IDX_SYS))
					avs_readdata_out <= {30'h0000_0000,
						clkgate_q, caproute_q};
				else
					avs_readdata_out <= 32'h0000_0000;
			end
		end
	end

	// ------------------------------------------------------------
	// Pins and status outputs
	// ------------------------------------------------------------
	always @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			comparator_enable_out          <= 1'b0;
			reference_select_out           <= 1'b0;
			positive_input_pin_release_out <= 1'b1;
			negative_input_pin_release_out <= 1'b1;
			comparator_out_pin_out         <= 1'b0;
			comparator_out_pin_oe_out      <= 1'b0;
			timer_two_channel_zero_out     <= 1'b0;
			capture_route_select_out       <= 1'b0;
			irq_out                        <= 1'b0;
			wakeup_out                     <= 1'b0;
		end else begin
			comparator_enable_out <= run;
			// Plus pin stays claimed whenever the block runs, whatever refsel_q selects
			reference_select_out  <= refsel_q;
			positive_input_pin_release_out <= ~run;
			negative_input_pin_release_out <= ~run;
			comparator_out_pin_out <= level_q;
			comparator_out_pin_oe_out <= pinen_q & run &
				~(dbg_sh_s2_q & dbg_en_s2_q);
			timer_two_channel_zero_out <= caproute_q & level_q;
			capture_route_select_out   <= caproute_q;
			irq_out    <= (irqen_q & flag_q);
			wakeup_out <= irqen_q & flag_q;
		end
	end

endmodule // acc_analog_comparator_control

// ### testbench/acc_comp_model.sv
`timescale 1ns/100ps
module acc_comp_model (
	input  wire       en_in,
	input  wire       refsel_in,
	input  wire [7:0] plus_in,
	input  wire [7:0] minus_in,
	input  wire [7:0] gap_in,
	output wire       level_out
);
	wire [7:0] pos = refsel_in ? gap_in : plus_in;
	// Off core parks low, like an unpowered stage
	assign level_out = en_in & (pos > minus_in);
endmodule // acc_comp_model

// ### testbench/acc_asserts.sv
`timescale 1ns/100ps
module acc_asserts (
	input logic        ref_clk_in,
	input logic        resetn_in,
	input logic [3:0]  avs_address_in,
	input logic        avs_write_in,
	input logic [31:0] avs_writedata_in,
	input logic        avs_waitrequest_out,
	input logic        debug_pin_enable_in,
	input logic        debug_shares_pin_in,
	input logic        comparator_enable_out,
	input logic        reference_select_out,
	input logic        positive_input_pin_release_out,
	input logic        comparator_out_pin_oe_out,
	input logic        timer_two_channel_zero_out,
	input logic        capture_route_select_out,
	input logic        irq_out,
	input logic        wakeup_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	// Module on implies the clock gate is open, so the write lands
	wire wr = avs_write_in && !avs_waitrequest_out && avs_address_in == 4'h0
		&& comparator_enable_out;
	wake_irq_a: assert property (wakeup_out == irq_out)
		else $error("wake mismatch");
	pin_release_a: assert property ($stable(comparator_enable_out) |->
		positive_input_pin_release_out != comparator_enable_out)
		else $error("pin release");
	debug_pin_a: assert property (debug_pin_enable_in && debug_shares_pin_in
		|=> ##[0:3] !comparator_out_pin_oe_out) else $error("debug oe");
	route_gate_a: assert property ((!capture_route_select_out) [*2] |->
		!timer_two_channel_zero_out) else $error("timer route");
	irq_drop_a: assert property (wr && !avs_writedata_in[4] |=> ##[0:1]
		!irq_out) else $error("irq held");
	enable_bit_a: assert property (wr |-> ##2 comparator_enable_out ==
		$past(avs_writedata_in[7], 2)) else $error("enable bit");
	ref_select_a: assert property (wr |-> ##2 reference_select_out ==
		$past(avs_writedata_in[6], 2)) else $error("ref select");
	oe_drop_a: assert property (wr && !avs_writedata_in[2] |=> ##[0:1]
		!comparator_out_pin_oe_out) else $error("oe held");
	cover property ($rose(irq_out));
	cover property ($rose(timer_two_channel_zero_out));
	cover property (wr && !avs_writedata_in[7]);
endmodule // acc_asserts
bind acc_analog_comparator_control acc_asserts acc_asserts_i (.*);

// ### testbench/acc_analog_comparator_control_tb_top.sv
`timescale 1ns/100ps
module acc_analog_comparator_control_tb_top;
	logic ref_clk_in = 0, resetn_in = 0, avs_read_in = 0, avs_write_in = 0;
	logic debug_pin_enable_in = 0, debug_shares_pin_in = 0, irq_out, wakeup_out;
	logic [3:0] avs_address_in = 0, avs_byteenable_in = 4'hF;
	logic [31:0] avs_writedata_in = 0, avs_readdata_out, q;
	logic avs_waitrequest_out, comparator_enable_out, reference_select_out;
	logic positive_input_pin_release_out, negative_input_pin_release_out;
	logic comparator_out_pin_out, comparator_out_pin_oe_out;
	logic timer_two_channel_zero_out, capture_route_select_out;
	logic [7:0] plus_v = 0, minus_v = 8'h64, gap_v = 0;
	wire comparator_raw_in;
	int n_fail = 0, total_checks = 0, seed = 3, r, lv, sel;
	acc_analog_comparator_control acc_analog_comparator_control_i (.*);
	acc_comp_model acc_comp_model_i (.en_in(comparator_enable_out),
		.refsel_in(reference_select_out), .plus_in(plus_v),
		.minus_in(minus_v), .gap_in(gap_v), .level_out(comparator_raw_in));
	always #4 ref_clk_in = ~ref_clk_in;
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic bus(bit w, logic [3:0] a, logic [7:0] d);
		int n = 0;
		avs_address_in <= a;
		avs_writedata_in <= {24'h0, d};
		avs_write_in <= w;
		avs_read_in <= !w;
		@(posedge ref_clk_in);
		while (avs_waitrequest_out !== 1'b0) begin
			if (n++ == 40) begin
				n_fail++;
				$display("[ERR] bus exp answer got timeout");
				break;
			end
			@(posedge ref_clk_in);
		end
		q = avs_readdata_out;
		avs_write_in <= 0;
		avs_read_in <= 0;
		@(posedge ref_clk_in);
	endtask
	task automatic step(int m, logic [7:0] p, bit l, bit h);
		logic [31:0] e;
		plus_v <= p;
		repeat (8) @(posedge ref_clk_in);
		e = 32'h90 | m | h << 5 | l << 3;
		bus(0, 0, 0);
		chk("sc", e, q);
		chk("irq", h, irq_out);
		bus(1, 0, 8'h90 | m);
		bus(0, 0, 0);
		chk("w0", e, q);
		bus(1, 0, 8'hB0 | m);
		bus(0, 0, 0);
		chk("w1c", e & ~32'h20, q);
		chk("irq0", 0, irq_out);
	endtask
	task end_of_test;
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#400000;
		n_fail++;
		end_of_test;
	end
	initial begin
		repeat (12) @(posedge ref_clk_in);
		resetn_in <= 1;
		@(posedge ref_clk_in);
		bus(0, 0, 0);
		chk("sc_rst", 0, q);
		bus(0, 1, 0);
		chk("sys_rst", 2, q);
		bus(0, 4'h7, 0);
		chk("unmap", 0, q);
		chk("rel", 1, negative_input_pin_release_out);
		for (int m = 0; m < 4; m++) begin
			bus(1, 0, 8'h90 | m);
			step(m, 8'hC8, 1, m[0]);
			step(m, 0, 0, m != 1);
		end
		repeat (6) begin
			r = $random(seed);
			{plus_v, minus_v, gap_v} <= r[23:0];
			sel = r[24];
			bus(1, 0, 8'h84 | sel << 6);
			repeat (8) @(posedge ref_clk_in);
			lv = (sel ? gap_v : plus_v) > minus_v;
			bus(0, 0, 0);
			chk("lvl", 32'h84 | sel << 6 | lv << 3, q & ~32'h20);
			chk("pin", lv, comparator_out_pin_out);
			chk("ref", sel, reference_select_out);
		end
		debug_pin_enable_in <= 1;
		debug_shares_pin_in <= 1;
		repeat (5) @(posedge ref_clk_in);
		chk("dbg", 0, comparator_out_pin_oe_out);
		debug_pin_enable_in <= 0;
		bus(1, 1, 3);
		repeat (3) @(posedge ref_clk_in);
		chk("cap", lv, timer_two_channel_zero_out);
		// Closed gate: the write is dropped, the old setting stays
		bus(1, 1, 0);
		bus(1, 0, 0);
		bus(0, 0, 0);
		chk("gate", 32'h84 | sel << 6, q & ~32'h28);
		bus(1, 1, 2);
		bus(1, 0, 0);
		repeat (4) @(posedge ref_clk_in);
		bus(0, 0, 0);
		chk("off", 0, q & ~32'h20);
		resetn_in <= 0;
		repeat (3) @(posedge ref_clk_in);
		resetn_in <= 1;
		@(posedge ref_clk_in);
		bus(0, 0, 0);
		chk("sc_rst2", 0, q);
		end_of_test;
	end
endmodule // acc_analog_comparator_control_tb_top
